// ### pkg/fesr_pkg.sv
// constants for the fault and event status register group
package fesr_pkg;
    // ========================================
    // bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_LATCHED = 4;

    // ========================================
    // register offsets
    localparam logic [7:0] OFF_MASK_ZERO   = 8'h2F;
    localparam logic [7:0] OFF_MASK_FIVE   = 8'h33;
    localparam logic [7:0] OFF_LATCHED_TWO = 8'h3B;
    localparam logic [7:0] OFF_LIVE_ZERO   = 8'h3C;
    localparam logic [7:0] OFF_CH_LIVE     = 8'h3D;

    // ========================================
    // field positions
    localparam int BIT_SUP_UP   = 7;
    localparam int BIT_SUP_LOW  = 6;
    localparam int BIT_VAD_UP   = 5;
    localparam int BIT_VAD_DOWN = 4;
    localparam int BIT_CLK_ERR  = 7;
    localparam int BIT_PLL_LOCK = 6;
    localparam int BIT_CH1      = 7;
    localparam int BIT_CH2      = 6;

    // ========================================
    // reset values
    localparam logic [7:0] RST_STATUS    = 8'h00;
    localparam logic [7:0] RST_MASK_FIVE = 8'h30;
    localparam logic [7:0] RST_MASK_ZERO = 8'hFF;
endpackage

// ### src/fesr_sticky_flags.sv
// bank of sticky event flags with read clear
`timescale 1ns/10ps
module fesr_sticky_flags #(
    parameter int N = 4
) (
    input  wire logic         mclk,
    input  wire logic         nrst,
    input  wire logic [N-1:0] set_pulse,
    input  wire logic         clr,
    output logic      [N-1:0] flags
);
    // ========================================
    // flag state
    logic [N-1:0] flags_reg;
    logic [N-1:0] flags_next;

    // set wins over clear so an event during the clearing read survives
    always_comb begin
        flags_next = flags_reg;
        if (clr) begin
            flags_next = '0;
        end
        flags_next = flags_next | set_pulse;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;
endmodule

// ### src/fesr_top.sv
// fault and event status registers with read port and mask gating
`timescale 1ns/10ps
module fesr_top
    import fesr_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_rd,
    input  wire logic              reg_wr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              supply_up_evt,
    input  wire logic              supply_low_evt,
    input  wire logic              vad_up_evt,
    input  wire logic              vad_down_evt,
    input  wire logic              clk_err_live,
    input  wire logic              pll_lock_live,
    input  wire logic              ch1_fault_live,
    input  wire logic              ch2_fault_live,
    output logic                   event_pending
);
    // ========================================
    // address decode
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    logic rd_latched;
    assign rd_latched = reg_rd && hit(reg_addr, OFF_LATCHED_TWO);

    // ========================================
    // latched events
    logic [NUM_LATCHED-1:0] evt_set;
    logic [NUM_LATCHED-1:0] latched_flags;
    logic [DATA_W-1:0]      latched_img;

    assign evt_set = {supply_up_evt, supply_low_evt,
                      vad_up_evt, vad_down_evt};

    fesr_sticky_flags #(
        .N (NUM_LATCHED)
    ) u_flags (
        .mclk      (mclk),
        .nrst      (nrst),
        .set_pulse (evt_set),
        .clr       (rd_latched),
        .flags     (latched_flags)
    );

    // flags occupy bits 7..4, low bits stay zero
    always_comb begin
        latched_img = RST_STATUS;
        latched_img[BIT_SUP_UP]   = latched_flags[3];
        latched_img[BIT_SUP_LOW]  = latched_flags[2];
        latched_img[BIT_VAD_UP]   = latched_flags[1];
        latched_img[BIT_VAD_DOWN] = latched_flags[0];
    end

    // ========================================
    // live status, sampled once so a read sees a stable value
    logic [DATA_W-1:0] live0_reg;
    logic [DATA_W-1:0] live0_next;
    logic [DATA_W-1:0] chlive_reg;
    logic [DATA_W-1:0] chlive_next;

    always_comb begin
        live0_next = RST_STATUS;
        chlive_next = RST_STATUS;
        live0_next[BIT_CLK_ERR]  = clk_err_live;
        live0_next[BIT_PLL_LOCK] = pll_lock_live;
        chlive_next[BIT_CH1]     = ch1_fault_live;
        chlive_next[BIT_CH2]     = ch2_fault_live;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            live0_reg  <= RST_STATUS;
            chlive_reg <= RST_STATUS;
        end else begin
            live0_reg  <= live0_next;
            chlive_reg <= chlive_next;
        end
    end

    // ========================================
    // mask registers, writable from the control port
    logic [DATA_W-1:0] mask5_reg;
    logic [DATA_W-1:0] mask5_next;
    logic [DATA_W-1:0] mask0_reg;
    logic [DATA_W-1:0] mask0_next;

    always_comb begin
        mask5_next = mask5_reg;
        mask0_next = mask0_reg;
        if (reg_wr && hit(reg_addr, OFF_MASK_FIVE)) begin
            mask5_next = reg_wdata;
        end
        if (reg_wr && hit(reg_addr, OFF_MASK_ZERO)) begin
            mask0_next = reg_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mask5_reg <= RST_MASK_FIVE;
            mask0_reg <= RST_MASK_ZERO;
        end else begin
            mask5_reg <= mask5_next;
            mask0_reg <= mask0_next;
        end
    end

    // ========================================
    // read data; writes to status offsets are ignored
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            case (reg_addr)
                OFF_LATCHED_TWO: begin
                    rdata_next = latched_img;
                end
                OFF_LIVE_ZERO: begin
                    rdata_next = live0_reg;
                end
                OFF_CH_LIVE: begin
                    rdata_next = chlive_reg;
                end
                OFF_MASK_FIVE: begin
                    rdata_next = mask5_reg;
                end
                OFF_MASK_ZERO: begin
                    rdata_next = mask0_reg;
                end
                default: begin
                    rdata_next = RST_STATUS;
                end
            endcase
        end
    end

    // ========================================
    // masked event summary; 1b in a mask bit hides the event
    logic pend_reg;
    logic pend_next;

    always_comb begin
        pend_next = (|(latched_img[7:4] & ~mask5_reg[7:4]))
                  | (|(live0_reg[7:6] & ~mask0_reg[7:6]));
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdata_reg <= RST_STATUS;
            pend_reg  <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            pend_reg  <= pend_next;
        end
    end

    assign reg_rdata     = rdata_reg;
    assign event_pending = pend_reg;

    // ========================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sup_up_set_a: assert property (supply_up_evt |=> latched_img[7])
        else $error("supply upper event not latched");
    sup_low_set_a: assert property (
        supply_low_evt |=> latched_img[6] until_with rd_latched)
        else $error("supply lower event not held until read");
    vad_up_set_a: assert property (vad_up_evt |=> latched_img[5])
        else $error("voice power up event not latched");
    vad_down_set_a: assert property (vad_down_evt |=> latched_img[4])
        else $error("voice power down event not latched");
    clk_err_live_a: assert property (
        clk_err_live ##1 (reg_rd && reg_addr == OFF_LIVE_ZERO)
        |=> reg_rdata[7])
        else $error("clock error not seen in live read");
    pll_live_a: assert property (
        live0_reg[6] == $past(pll_lock_live))
        else $error("pll lock live bit stale");
    ch1_live_a: assert property (
        !ch1_fault_live |=> !chlive_reg[7])
        else $error("channel 1 fault bit without fault");
    ch2_live_a: assert property (
        ch2_fault_live |=> chlive_reg[6])
        else $error("channel 2 fault bit missing");
    low_bits_zero_a: assert property (
        reg_rd && reg_addr >= OFF_LATCHED_TWO && reg_addr <= OFF_CH_LIVE
        |=> reg_rdata[3:0] == 4'h0)
        else $error("reserved status bits not zero");
    mask5_gate_a: assert property (
        latched_img[7] && !mask5_reg[7] |=> event_pending)
        else $error("unmasked supply event not pending");
    mask0_gate_a: assert property (
        !(|(latched_img[7:4] & ~mask5_reg[7:4]))
        && !(|(live0_reg[7:6] & ~mask0_reg[7:6])) |=> !event_pending)
        else $error("masked events raised pending");
    read_clear_a: assert property (
        rd_latched && !supply_up_evt |=> !latched_img[7])
        else $error("latched flag not cleared by read");

    read_clear_c: cover property (latched_img[7] && rd_latched);
    set_on_read_c: cover property (rd_latched && supply_up_evt);
    unmask_c: cover property (reg_wr && reg_addr == OFF_MASK_ZERO
                              && !reg_wdata[7]);
endmodule

// ### testbench/fesr_top_tb.sv
// self-checking bench for the fault and event status registers
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module fesr_top_tb;
    import fesr_pkg::*;
    // ========================================
    // signals
    logic              mclk;
    logic              nrst;
    logic [ADDR_W-1:0] reg_addr;
    logic              reg_rd;
    logic              reg_wr;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic [3:0]        evt;
    logic [3:0]        lv;
    logic              event_pending;
    int                n_mismatch;
    int                n_tests;

    fesr_top dut_u (
        .mclk          (mclk),
        .nrst          (nrst),
        .reg_addr      (reg_addr),
        .reg_rd        (reg_rd),
        .reg_wr        (reg_wr),
        .reg_wdata     (reg_wdata),
        .reg_rdata     (reg_rdata),
        .supply_up_evt (evt[3]),
        .supply_low_evt(evt[2]),
        .vad_up_evt    (evt[1]),
        .vad_down_evt  (evt[0]),
        .clk_err_live  (lv[3]),
        .pll_lock_live (lv[2]),
        .ch1_fault_live(lv[1]),
        .ch2_fault_live(lv[0]),
        .event_pending (event_pending)
    );

    always #5 mclk = ~mclk;

    // ========================================
    // bus helpers; inputs move 1 ns after the edge
    task tick;
        @(posedge mclk);
        #1;
    endtask

    // strobe is dropped one cycle before the next task may raise it
    task rdc(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        tick;
        reg_rd = 1'b0;
        `CHK(reg_rdata, e)
        tick;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick;
        reg_wr = 1'b0;
        tick;
    endtask

    task pulse(input int i);
        evt[i] = 1'b1;
        tick;
        evt[i] = 1'b0;
    endtask

    // ========================================
    // scenarios
    task t_reset;
        rdc(OFF_LATCHED_TWO, 8'h00);
        rdc(OFF_LIVE_ZERO, 8'h00);
        rdc(OFF_CH_LIVE, 8'h00);
        rdc(OFF_MASK_ZERO, 8'hFF);
        rdc(OFF_MASK_FIVE, 8'h30);
        rdc(8'h40, 8'h00);
        `CHK(event_pending, 1'b0)
    endtask

    task t_latched;
        for (int i = 0; i < 4; i++) begin
            pulse(3 - i);
            tick;
            `CHK(event_pending, (i < 2) ? 1'b1 : 1'b0)
            rdc(OFF_LATCHED_TWO, 8'h80 >> i);
            rdc(OFF_LATCHED_TWO, 8'h00);
        end
    endtask

    task t_live;
        logic [3:0] pat [5];
        pat = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hF};
        for (int i = 0; i < 5; i++) begin
            lv = pat[i];
            tick;
            rdc(OFF_LIVE_ZERO, {pat[i][3:2], 6'h00});
            rdc(OFF_CH_LIVE, {pat[i][1:0], 6'h00});
        end
        `CHK(event_pending, 1'b0)
        lv = 4'h0;
        tick;
    endtask

    // only the clock error is let through, then all four latched events, with vad power up pulsed
    task t_mask;
        wr(OFF_MASK_ZERO, 8'h7F);
        lv = 4'h4;
        tick;
        tick;
        `CHK(event_pending, 1'b0)
        lv = 4'h8;
        tick;
        tick;
        `CHK(event_pending, 1'b1)
        lv = 4'h0;
        wr(OFF_MASK_ZERO, 8'hFF);
        wr(OFF_MASK_FIVE, 8'h00);
        pulse(1);
        tick;
        `CHK(event_pending, 1'b1)
        wr(OFF_LATCHED_TWO, 8'hFF);
        rdc(OFF_LATCHED_TWO, 8'h20);
        wr(OFF_MASK_FIVE, 8'h30);
    endtask

    // an event in the read cycle must survive the clear
    task t_recur;
        evt[3] = 1'b1;
        tick;
        reg_addr = OFF_LATCHED_TWO;
        reg_rd = 1'b1;
        tick;
        evt[3] = 1'b0;
        reg_rd = 1'b0;
        `CHK(reg_rdata, 8'h80)
        tick;
        rdc(OFF_LATCHED_TWO, 8'h80);
        rdc(OFF_LATCHED_TWO, 8'h00);
    endtask

    // ========================================
    // verdict
    task summarize;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        reg_addr = 8'h00;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        evt = 4'h0;
        lv = 4'h0;
        n_mismatch = 0;
        n_tests = 0;
        repeat (16) @(posedge mclk);
        #1;
        nrst = 1'b1;
        tick;
        t_reset;
        t_latched;
        t_live;
        t_mask;
        t_recur;
        summarize;
    end

    // the tests take well under 200 cycles
    initial begin
        repeat (2000) @(posedge mclk);
        n_mismatch++;
        summarize;
    end
endmodule
